// ### sfs_pkg.sv
// Constants shared by the system fault supervisor files
// Assumes a 100 MHz internal clock
package sfs_pkg;
   // ***********************************************************
   // Register offsets (plain register port, 8-bit addresses)
   // ***********************************************************
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h01;
   localparam logic [7:0] ADDR_INTERRUPT_SOURCE_REG = 8'h02;
   localparam logic [7:0] ADDR_INTMSK = 8'h03;
   localparam logic [7:0] ADDR_MRDB   = 8'h04;

   // ***********************************************************
   // Field positions and reset values
   // ***********************************************************
   localparam int          CTRL_EN_BIT   = 0;
   localparam int          CTRL_THR_LSB  = 1;
   localparam int          THR_W         = 3;
   localparam int          CTRL_HYS_LSB  = 4;
   localparam int          HYS_W         = 2;
   localparam logic [7:0]  CTRL_RESET    = 8'h01;
   localparam logic [7:0]  INTMSK_RESET  = 8'h00;
   localparam int          NUM_EVT       = 4;
   localparam int          EVT_LOW_SYS_EVENT    = 0;
   localparam int          EVT_WARN120   = 1;
   localparam int          EVT_WARN140   = 2;
   localparam int          EVT_THERMSD   = 3;

   // ***********************************************************
   // Manual reset debounce, seconds
   // ***********************************************************
   localparam logic [3:0]  MR_SEC_DEFAULT = 4'h7;
   localparam logic [3:0]  MR_SEC_MIN     = 4'h3;
   localparam logic [3:0]  MR_SEC_MAX     = 4'hA;
   localparam int          CLK_HZ         = 100_000_000;
   localparam int          SEC_MS         = 1000;

   // Supervisor states
   typedef enum logic [1:0]
   {
      ST_RUN  = 2'b00,
      ST_SHDN = 2'b01,
      ST_OTL  = 2'b10
   } sfs_state_type;
endpackage : sfs_pkg

// ### sfs_sync.sv
// Two-flop synchroniser bank for comparator and pin inputs
// Assumes inputs asynchronous to I_CLK
`timescale 1ns/1ps
`default_nettype none
module sfs_sync
#(
   parameter int W = 8
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   input  wire logic [W-1:0] rst_val,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta;

   // Two stages; first stage read only by the second
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta <= rst_val; // Safe levels while held in reset
         q    <= rst_val;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : sfs_sync
`default_nettype wire

// ### sfs_supervisor.sv
// System fault supervisor: shutdown, reset bus, warning interrupts
// Assumes analog comparators deliver levels; register port is plain
// Operation
// (R01) Undervoltage comparator active forces global shutdown
// (R02) Overvoltage comparator trip forces global shutdown
// (R03) Supply below low threshold raises low-system event, no shutdown
// (R04) Low detection enabled after reset, disabled by clearing enable bit
// (R05) Threshold field drives comparator reference selection
// (R06) Hysteresis field selects recovery level of low state
// (R07) Above 165 C record thermal event and enter shutdown
// (R08) Separate warning events at 120 C and 140 C
// (R09) Shutdown released after 15 C cooling, logic supply re-enabled
// (R10) Overtemperature stays latched to 150 C; release needs turn-on
// (R11) Charger thermal overload switches off only the charger
// (R12) Reset bus spares the fuel gauge, which keeps running
// (R13) Faults or manual reset drive reset bus, registers to default; the code keeps the interrupt source bits through it
// (R14) Manual reset held low for 7 s asserts reset bus
// (R15) Debounce programmable 3 s to 10 s in 1 s steps
// (R16) Interrupt output releases as read of last active source starts
// (R17) Masked events keep status but do not drive the interrupt
// (R18) All async inputs pass a two-flop synchroniser; I_TURN_ON reaches the state machine unsynchronised
`timescale 1ns/1ps
`default_nettype none
module sfs_supervisor
   import sfs_pkg::*;
#(
   parameter int TICK_CYC = CLK_HZ / SEC_MS * SEC_MS
)
(
   input  wire logic       I_CLK,
   input  wire logic       I_RST_N,
   input  wire logic       I_SYS_UV,
   input  wire logic       I_SYS_OV,
   input  wire logic       I_SYS_LOW,
   input  wire logic       I_T120,
   input  wire logic       I_T140,
   input  wire logic       I_T150,
   input  wire logic       I_T165,
   input  wire logic       I_CHG_THERM,
   input  wire logic       I_MR_N,
   input  wire logic       I_TURN_ON,
   input  wire logic [7:0] I_ADDR,
   input  wire logic [7:0] I_WDATA,
   input  wire logic       I_WR,
   input  wire logic       I_RD,
   output var  logic [7:0] O_RDATA,
   output var  logic       O_INT_N,
   output var  logic       O_SHUTDOWN,
   output var  logic       O_RESET_BUS,
   output var  logic       O_FG_KEEP,
   output var  logic       O_LOGIC_SUPPLY_EN,
   output var  logic       O_CHG_OFF,
   output var  logic       O_LOW_DET_EN,
   output var  logic [2:0] O_LOW_THR_SEL,
   output var  logic [1:0] O_LOW_HYS_SEL
);
   // Elaboration check on the tick length
   if (TICK_CYC < 1)
   begin : g_bad_tick
      $error("TICK_CYC must be at least one");
   end

   // ***********************************************************
   // Input synchronisers
   // ***********************************************************
   logic [9:0] raw_in;
   logic [9:0] syn;
   assign raw_in = {I_MR_N, I_CHG_THERM, I_T165, I_T150, I_T140,
                    I_T120, I_SYS_LOW, I_SYS_OV, I_SYS_UV, 1'b0};
   sfs_sync #(.W(10)) u_sync
   (
      .clk     (I_CLK),
      .rst_n   (I_RST_N),
      .d       (raw_in),
      .rst_val (10'h202), // Undervoltage asserted, pin idle high
      .q       (syn)
   ); // R18
   wire uv    = syn[1];
   wire ov    = syn[2];
   wire low   = syn[3];
   wire t120  = syn[4];
   wire t140  = syn[5];
   wire t150  = syn[6];
   wire t165  = syn[7];
   wire chgt  = syn[8];
   wire mr_n  = syn[9];

   // ***********************************************************
   // Registers
   // ***********************************************************
   logic [7:0]         ctrl;
   logic [3:0]         mr_sec;
   logic [NUM_EVT-1:0] isrc;
   logic [NUM_EVT-1:0] imask;
   logic               por;
   sfs_state_type      state;
   sfs_state_type      next_state;

   wire wr_ctrl = I_WR && (I_ADDR == ADDR_CTRL);
   wire wr_msk  = I_WR && (I_ADDR == ADDR_INTMSK);
   wire wr_mr   = I_WR && (I_ADDR == ADDR_MRDB);
   wire wr_src  = I_WR && (I_ADDR == ADDR_INTERRUPT_SOURCE_REG);
   wire rd_src  = I_RD && (I_ADDR == ADDR_INTERRUPT_SOURCE_REG);
   wire mr_ok   = (I_WDATA[3:0] >= MR_SEC_MIN) &&
                  (I_WDATA[3:0] <= MR_SEC_MAX); // R15

   // Control fields drive comparator selects
   assign O_LOW_DET_EN  = ctrl[CTRL_EN_BIT];                       // R04
   assign O_LOW_THR_SEL = ctrl[CTRL_THR_LSB +: THR_W];             // R05
   assign O_LOW_HYS_SEL = ctrl[CTRL_HYS_LSB +: HYS_W];             // R06

   // Configuration writes; por returns them to defaults
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N || por)
      begin
         ctrl   <= CTRL_RESET;  // R13
         imask  <= INTMSK_RESET[NUM_EVT-1:0];
         mr_sec <= MR_SEC_DEFAULT;
      end
      else
      begin
         if (wr_ctrl)
            ctrl <= I_WDATA;
         if (wr_msk)
            imask <= I_WDATA[NUM_EVT-1:0];
         if (wr_mr && mr_ok)
            mr_sec <= I_WDATA[3:0]; // R15
      end
   end

   // ***********************************************************
   // Event edges; low state ends via hysteresis in comparator
   // ***********************************************************
   logic low_d, t120_d, t140_d, t165_d;
   wire low_q = low && ctrl[CTRL_EN_BIT]; // R04
   wire [NUM_EVT-1:0] evt = {t165 && !t165_d, t140 && !t140_d,
                             t120 && !t120_d,
                             low_q && !low_d}; // R03 R08
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
      begin
         low_d  <= 1'b0;
         t120_d <= 1'b0;
         t140_d <= 1'b0;
         t165_d <= 1'b0;
      end
      else
      begin
         low_d  <= low_q;
         t120_d <= t120;
         t140_d <= t140;
         t165_d <= t165;
      end
   end

   // Sticky source bits: set wins over clear; read of source clears
   wire [NUM_EVT-1:0] clr = rd_src ? {NUM_EVT{1'b1}} :
                            (wr_src ? I_WDATA[NUM_EVT-1:0] : '0);
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
         isrc <= '0;
      else
         isrc <= (isrc & ~clr) | evt; // R07 R17
   end

   // Interrupt releases as soon as the read of the source starts
   assign O_INT_N = !(|(isrc & ~imask) && !rd_src); // R16 R17

   // ***********************************************************
   // Shutdown state machine
   // ***********************************************************
   always_comb
   begin
      case (state)
         ST_RUN:
            if (t165)
               next_state = ST_OTL;       // R07
            else if (uv || ov)
               next_state = ST_SHDN;      // R01 R02
            else
               next_state = ST_RUN;
         ST_SHDN:
            if (t165)
               next_state = ST_OTL;
            else if (!uv && !ov)
               next_state = ST_RUN;
            else
               next_state = ST_SHDN;
         ST_OTL:
            // Comparator at 150 C gives the 15 C hysteresis
            if (!t150 && !t165 && I_TURN_ON)
               next_state = ST_RUN;       // R09 R10
            else
               next_state = ST_OTL;
         default:
            next_state = ST_SHDN;
      endcase
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
         state <= ST_SHDN;
      else
         state <= next_state;
   end

   // ***********************************************************
   // Manual reset debounce: second tick and seconds counter
   // ***********************************************************
   localparam int TW = $clog2(TICK_CYC + 1);
   logic [TW-1:0] tick_cnt;
   logic [3:0]    sec_cnt;
   logic          mr_fire;
   wire tick = (tick_cnt == TW'(TICK_CYC - 1));
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N || mr_n)
      begin
         tick_cnt <= '0;
         sec_cnt  <= '0;
         mr_fire  <= 1'b0;
      end
      else
      begin
         tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
         if (tick && sec_cnt != mr_sec)
            sec_cnt <= sec_cnt + 4'h1;
         // Held while the pin stays low; por reloads mr_sec
         mr_fire <= mr_fire || (sec_cnt == mr_sec); // R14 R15
      end
   end

   // Reset bus and outputs
   wire thermal_sd = (state == ST_OTL);
   assign por = (state != ST_RUN) || mr_fire; // R13
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
      begin
         O_SHUTDOWN        <= 1'b1;
         O_RESET_BUS       <= 1'b1;
         O_LOGIC_SUPPLY_EN <= 1'b0;
         O_CHG_OFF         <= 1'b0;
      end
      else
      begin
         O_SHUTDOWN        <= (next_state != ST_RUN);
         O_RESET_BUS       <= por;                 // R13 R14
         O_LOGIC_SUPPLY_EN <= !thermal_sd;         // R09
         O_CHG_OFF         <= chgt;                // R11
      end
   end
   assign O_FG_KEEP = 1'b1; // R12

   // Read data one cycle after the read strobe
   wire [7:0] rd_mux =
      (I_ADDR == ADDR_CTRL)   ? ctrl :
      (I_ADDR == ADDR_STATUS) ? {4'h0, low_q, t165, thermal_sd,
                                 state != ST_RUN} :
      (I_ADDR == ADDR_INTERRUPT_SOURCE_REG) ? {4'h0, isrc} :
      (I_ADDR == ADDR_INTMSK) ? {4'h0, imask} :
      (I_ADDR == ADDR_MRDB)   ? {4'h0, mr_sec} : 8'h00;
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
         O_RDATA <= 8'h00;
      else
         O_RDATA <= I_RD ? rd_mux : 8'h00;
   end

   // ***********************************************************
   // Assertions
   // ***********************************************************
   shdn_uv_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      uv |=> O_SHUTDOWN) else $error("uv no shutdown"); // R01
   shdn_ov_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      ov |=> O_SHUTDOWN) else $error("ov no shutdown"); // R02
   low_evt_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (low_q && !low_d && !por) |=> isrc[EVT_LOW_SYS_EVENT])
      else $error("low event lost"); // R03
   low_dis_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      !ctrl[CTRL_EN_BIT] |=> !low_d) else $error("low while off"); // R04
   therm_sd_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      t165 |=> thermal_sd)
      else $error("thermal not latched"); // R07
   therm_evt_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (t165 && !t165_d) |=> isrc[EVT_THERMSD])
      else $error("thermal event lost"); // R07
   warn_evt_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (t140 && !t140_d) |=> isrc[EVT_WARN140])
      else $error("warn140 lost"); // R08
   otl_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (thermal_sd && !I_TURN_ON) |=> thermal_sd)
      else $error("otl released"); // R10
   chg_only_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (chgt && state == ST_RUN && !t165 && !uv && !ov) |=> !thermal_sd)
      else $error("charger caused sd"); // R11
   int_rel_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      rd_src |-> O_INT_N) else $error("int not released"); // R16
   mask_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      ((isrc & ~imask) == '0) |-> O_INT_N) else $error("masked int"); // R17
   mr_bus_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      mr_fire |=> O_RESET_BUS) else $error("mr no reset"); // R14

   cov_mr: cover property (@(posedge I_CLK) mr_fire);
   cov_otl: cover property (@(posedge I_CLK) thermal_sd ##1 !thermal_sd);
   cov_int: cover property (@(posedge I_CLK) !O_INT_N ##1 rd_src);
endmodule : sfs_supervisor
`default_nettype wire

// ### sfs_cmp_model.sv
// Comparator bank model facing the fault supervisor
// Assumes the bench sets die temperature and supply flags
`timescale 1ns/1ps
`default_nettype none
module sfs_cmp_model
(
   input  wire logic [7:0] i_temp,
   input  wire logic       i_uv,
   input  wire logic       i_ov,
   input  wire logic       i_low,
   input  wire logic       i_low_en,
   output var  logic       o_uv,
   output var  logic       o_ov,
   output var  logic       o_low,
   output var  logic [3:0] o_temp
);
   // ***********************************************************
   // Supply comparators; low comparator unpowered when disabled
   // ***********************************************************
   assign o_uv  = i_uv;
   assign o_ov  = i_ov;
   assign o_low = i_low & i_low_en;
   // Die comparators 120, 140, 150, 165 degrees
   assign o_temp = {i_temp >= 8'hA5, i_temp >= 8'h96,
                    i_temp >= 8'h8C, i_temp >= 8'h78};
endmodule : sfs_cmp_model
`default_nettype wire

// ### system_fault_supervisor_tb.sv
// Self-checking bench for the fault supervisor
// Assumes sfs_pkg, sfs_supervisor and sfs_cmp_model compiled first
`timescale 1ns/1ps
`default_nettype none
module system_fault_supervisor_tb;
   import sfs_pkg::*;
   logic       clk = 1'b0, rst_n = 1'b0, uv = 1'b1, ov = 1'b0;
   logic       low = 1'b0, chg = 1'b0, mr_n = 1'b1, ton = 1'b0;
   logic       wr = 1'b0, rd = 1'b0, ri;
   logic [7:0] addr = 8'h00, wdata = 8'h00, temp = 8'h19, d;
   wire  logic c_uv, c_ov, c_low, int_n, shdn, rbus, fg, lse;
   wire  logic choff, lden;
   wire  logic [3:0] c_t;
   wire  logic [7:0] rdata;
   wire  logic [2:0] thr;
   wire  logic [1:0] hys;
   int         error_cnt = 0;
   int         tests_run = 0;

   // Clock, 10 ns period
   always #5 clk = ~clk;

   sfs_cmp_model CMP (.i_temp(temp), .i_uv(uv), .i_ov(ov),
      .i_low(low), .i_low_en(lden), .o_uv(c_uv), .o_ov(c_ov),
      .o_low(c_low), .o_temp(c_t));

   sfs_supervisor #(.TICK_CYC(10)) DUT (.I_CLK(clk), .I_RST_N(rst_n),
      .I_SYS_UV(c_uv), .I_SYS_OV(c_ov), .I_SYS_LOW(c_low),
      .I_T120(c_t[0]), .I_T140(c_t[1]), .I_T150(c_t[2]),
      .I_T165(c_t[3]), .I_CHG_THERM(chg), .I_MR_N(mr_n),
      .I_TURN_ON(ton), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
      .I_RD(rd), .O_RDATA(rdata), .O_INT_N(int_n), .O_SHUTDOWN(shdn),
      .O_RESET_BUS(rbus), .O_FG_KEEP(fg), .O_LOGIC_SUPPLY_EN(lse),
      .O_CHG_OFF(choff), .O_LOW_DET_EN(lden), .O_LOW_THR_SEL(thr),
      .O_LOW_HYS_SEL(hys));

   // ***********************************************************
   // Shared helpers
   // ***********************************************************
   task automatic chk(input string n, input logic [7:0] s, e);
      tests_run++;
      if (s !== e)
      begin
         error_cnt++;
         $display("MISMATCH %s exp %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic wreg(input logic [7:0] a, v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg

   // Read; interrupt line captured during the strobe cycle
   task automatic rreg(input logic [7:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      #1 ri = int_n;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rreg

   task automatic stop_test;
      $display("Checks %0d, errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   // ***********************************************************
   // Scenarios
   // ***********************************************************
   task automatic t_reset;
      cyc(6);
      chk("uv shdn", shdn, 1);
      @(posedge clk);
      uv <= 1'b0;
      cyc(6);
      chk("run", {rbus, shdn}, 0);
      chk("fg", fg, 1);
      chk("lden", lden, 1);
      rreg(ADDR_CTRL);
      chk("ctrl", d, CTRL_RESET);
      rreg(ADDR_INTMSK);
      chk("mask", d, INTMSK_RESET);
      rreg(ADDR_MRDB);
      chk("mrdb", d, 8'h07);
      rreg(8'h10);
      chk("unmapped", d, 8'h00);
   endtask : t_reset

   // Faults drive shutdown and reset bus, config back to default
   task automatic t_faults;
      for (int i = 0; i < 2; i++)
      begin
         wreg(ADDR_CTRL, 8'h35);
         @(posedge clk);
         {ov, uv} <= 2'(i + 1);
         cyc(6);
         chk("fault", {rbus, shdn}, 3);
         @(posedge clk);
         {ov, uv} <= 2'b00;
         cyc(6);
         chk("recover", shdn, 0);
         rreg(ADDR_CTRL);
         chk("ctrl dflt", d, CTRL_RESET);
      end
   endtask : t_faults

   task automatic t_low;
      wreg(ADDR_CTRL, 8'h2B);
      cyc(1);
      chk("thr", thr, 5);
      chk("hys", hys, 2);
      @(posedge clk);
      low <= 1'b1;
      cyc(6);
      chk("no shdn", shdn, 0);
      chk("int low", int_n, 0);
      rreg(ADDR_INTERRUPT_SOURCE_REG);
      chk("src low", d, 8'h01);
      chk("int rd", ri, 1);
      chk("int clr", int_n, 1);
      wreg(ADDR_CTRL, 8'h2A);
      @(posedge clk);
      low <= 1'b0;
      cyc(6);
      chk("lden off", lden, 0);
      @(posedge clk);
      low <= 1'b1;
      cyc(6);
      rreg(ADDR_INTERRUPT_SOURCE_REG);
      chk("src off", d, 8'h00);
      @(posedge clk);
      low <= 1'b0;
   endtask : t_low

   task automatic t_warn;
      @(posedge clk);
      temp <= 8'h82;
      cyc(6);
      @(posedge clk);
      temp <= 8'h91;
      cyc(6);
      chk("int warn", int_n, 0);
      rreg(ADDR_INTERRUPT_SOURCE_REG);
      chk("src warn", d, 8'h06);
      @(posedge clk);
      temp <= 8'h19;
      wreg(ADDR_INTMSK, 8'h02);
      @(posedge clk);
      temp <= 8'h82;
      cyc(6);
      chk("int msk", int_n, 1);
      rreg(ADDR_INTERRUPT_SOURCE_REG);
      chk("src msk", d, 8'h02);
      wreg(ADDR_INTMSK, 8'h00);
   endtask : t_warn

   task automatic t_therm;
      @(posedge clk);
      temp <= 8'hAA;
      cyc(6);
      chk("otp", {lse, shdn}, 1);
      rreg(ADDR_STATUS);
      chk("latched", d & 8'h03, 8'h03);
      @(posedge clk);
      temp <= 8'h9B;
      cyc(6);
      chk("hold 150", shdn, 1);
      @(posedge clk);
      temp <= 8'h91;
      cyc(6);
      chk("no turn-on", shdn, 1);
      @(posedge clk);
      ton <= 1'b1;
      @(posedge clk);
      ton <= 1'b0;
      cyc(6);
      chk("released", {lse, shdn}, 2);
      @(posedge clk);
      temp <= 8'h19;
      chg <= 1'b1;
      cyc(6);
      chk("chg", {shdn, choff}, 1);
      @(posedge clk);
      chg <= 1'b0;
      cyc(6);
      chk("chg clr", choff, 0);
   endtask : t_therm

   task automatic t_mr;
      chk("int therm", int_n, 0);
      wreg(ADDR_INTERRUPT_SOURCE_REG, 8'h04);
      rreg(ADDR_INTERRUPT_SOURCE_REG);
      chk("src w1c", d, 8'h08);
      wreg(ADDR_MRDB, 8'h02);
      rreg(ADDR_MRDB);
      chk("mr lo", d, 8'h07);
      wreg(ADDR_MRDB, 8'h0B);
      wreg(ADDR_MRDB, 8'h03);
      rreg(ADDR_MRDB);
      chk("mr set", d, 8'h03);
      wreg(ADDR_CTRL, 8'h2B);
      @(posedge clk);
      mr_n <= 1'b0;
      cyc(25);
      chk("mr early", rbus, 0);
      cyc(15);
      chk("mr fire", rbus, 1);
      @(posedge clk);
      mr_n <= 1'b1;
      cyc(6);
      chk("mr end", rbus, 0);
      rreg(ADDR_CTRL);
      chk("mr ctrl", d, CTRL_RESET);
   endtask : t_mr

   // Main sequence
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_faults();
      t_low();
      t_warn();
      t_therm();
      t_mr();
      stop_test();
   end

   // Watchdog against a hang
   initial
   begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      stop_test();
   end
endmodule : system_fault_supervisor_tb
`default_nettype wire
